// File: cst_core.sv
// Sequencer for subtract, test, register copies, software trap, return and bit branches.
// Assumes memory returns mem_rdata_i in the same cycle that mem_rd_o and mem_addr_o stand.
`timescale 1ns/1ps
module cst_core
   import cst_pkg::*;
#(
   parameter logic [15:0] TRAP_VECTOR = TRAP_VECTOR_ADDR
)(
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [7:0]  mem_rdata_i,
   output logic [15:0]      mem_addr_o,
   output logic             mem_rd_o,
   output logic             mem_wr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             opcode_fetch_o,
   output logic [7:0]       acc_o,
   output logic [7:0]       idx_o,
   output logic [7:0]       sp_o,
   output logic [15:0]      pc_o,
   output logic [4:0]       condition_flags_reg_o
);
   cst_state_t  state_ff;
   logic [15:0] pc_ff;
   logic [15:0] ea_ff;
   logic [15:0] addr_ff;
   logic [7:0]  acc_ff;
   logic [7:0]  idx_ff;
   logic [7:0]  sp_ff;
   logic [7:0]  op_ff;
   logic [7:0]  hold_ff;
   logic [7:0]  wdata_ff;
   logic [4:0]  flags_ff;
   logic [3:0]  cnt_ff;
   logic [2:0]  step_ff;
   logic        rd_ff;
   logic        wr_ff;
   logic        bit_ff;
   logic [7:0]  alu_b;
   logic [7:0]  alu_res;
   logic        alu_n;
   logic        alu_z;
   logic        alu_c;
   logic        is_tst;

   function automatic logic [3:0] cycles_of(input logic [7:0] op);
      logic [3:0] c;
      c = CYC_OTHER;
      if (op[3:0] == LO_SUB && op[7:4] >= HI_IMMEDIATE_OPERAND) begin
         unique case (op[7:4])
            HI_IMMEDIATE_OPERAND: c = CYC_SUB_IMM;
            HI_DIRECT:            c = CYC_SUB_DIR;
            HI_EXTENDED_ABSOLUTE: c = CYC_SUB_EXT;
            HI_INDEXED_WORD:      c = CYC_SUB_IX2;
            HI_INDEXED_BYTE:      c = CYC_SUB_IX1;
            default:              c = CYC_SUB_IX;
         endcase
      end else if (op[3:0] == LO_TEST && op[7:4] >= HI_TST_DIRECT && op[7:4] <= HI_TST_NONE) begin
         unique case (op[7:4])
            HI_TST_DIRECT: c = CYC_TST_DIR;
            HI_TST_BYTE:   c = CYC_TST_IX1;
            HI_TST_NONE:   c = CYC_TST_IX;
            default:       c = CYC_TST_INH;
         endcase
      end else if (op[7:4] == HI_BIT_BRANCH) begin
         c = CYC_BIT_BRANCH;
      end else if (op == OP_SOFTWARE_TRAP) begin
         c = CYC_TRAP;
      end else if (op == OP_RETURN_FROM_TRAP) begin
         c = CYC_RETURN;
      end else if (op == OP_COPY_ACC_TO_INDEX || op == OP_COPY_INDEX_TO_ACC) begin
         c = CYC_COPY;
      end
      return c;
   endfunction

   function automatic logic is_test(input logic [7:0] op);
      return op[3:0] == LO_TEST && op[7:4] >= HI_TST_DIRECT && op[7:4] <= HI_TST_NONE;
   endfunction

   // Pad to the documented count; cnt_ff is the cycle index after the opcode fetch
   function automatic cst_state_t finish(input logic [3:0] cnt, input logic [7:0] op);
      return (4'(cnt + 4'h1) >= cycles_of(op)) ? CST_FETCH : CST_PAD;
   endfunction

   assign is_tst = is_test(op_ff);
   assign alu_b  = (state_ff == CST_INH) ? ((op_ff == OP_TEST_ACC) ? acc_ff : idx_ff) : mem_rdata_i;

   cst_alu u_alu (
      .a_i      (acc_ff),
      .b_i      (alu_b),
      .test_i   (is_tst),
      .res_o    (alu_res),
      .neg_o    (alu_n),
      .zero_o   (alu_z),
      .borrow_o (alu_c)
   );

   // Cycle index within the current instruction
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff <= 4'h0;
      end else if (state_ff == CST_FETCH) begin
         cnt_ff <= 4'h1;
      end else begin
         cnt_ff <= 4'(cnt_ff + 4'h1);
      end
   end

   // Main sequencer: registers, bus and state move together
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= CST_FETCH;
         pc_ff    <= PC_RST;
         ea_ff    <= 16'h0000;
         addr_ff  <= PC_RST;
         acc_ff   <= 8'h00;
         idx_ff   <= 8'h00;
         sp_ff    <= SP_RST;
         op_ff    <= 8'h00;
         hold_ff  <= 8'h00;
         wdata_ff <= 8'h00;
         flags_ff <= FLAGS_RST;
         step_ff  <= 3'h0;
         rd_ff    <= 1'b1;
         wr_ff    <= 1'b0;
         bit_ff   <= 1'b0;
      end else begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         unique case (state_ff)
            CST_FETCH: begin
               op_ff <= mem_rdata_i;
               pc_ff <= pc_ff + 16'h0001;
               if (mem_rdata_i == OP_COPY_ACC_TO_INDEX) begin
                  idx_ff   <= acc_ff;
                  state_ff <= CST_PAD;
               end else if (mem_rdata_i == OP_COPY_INDEX_TO_ACC) begin
                  acc_ff   <= idx_ff;
                  state_ff <= CST_PAD;
               end else if (mem_rdata_i == OP_SOFTWARE_TRAP) begin
                  step_ff  <= 3'h0;
                  addr_ff  <= {STACK_PAGE, sp_ff};
                  wdata_ff <= pc_ff[7:0] + 8'h01;
                  wr_ff    <= 1'b1;
                  state_ff <= CST_PUSH;
               end else if (mem_rdata_i == OP_RETURN_FROM_TRAP) begin
                  step_ff  <= 3'h0;
                  sp_ff    <= sp_ff + 8'h01;
                  addr_ff  <= {STACK_PAGE, 8'(sp_ff + 8'h01)};
                  rd_ff    <= 1'b1;
                  state_ff <= CST_PULL;
               end else if (is_test(mem_rdata_i) && (mem_rdata_i[7:4] == HI_TST_ACC
                            || mem_rdata_i[7:4] == HI_TST_INDEX)) begin
                  state_ff <= CST_INH;
               end else if ((is_test(mem_rdata_i) && mem_rdata_i[7:4] == HI_TST_NONE)
                            || (mem_rdata_i[3:0] == LO_SUB && mem_rdata_i[7:4] == HI_INDEXED_NONE)) begin
                  addr_ff  <= {ZERO_PAGE, idx_ff};
                  rd_ff    <= 1'b1;
                  state_ff <= CST_READ;
               end else if (is_test(mem_rdata_i) || mem_rdata_i[7:4] == HI_BIT_BRANCH
                            || (mem_rdata_i[3:0] == LO_SUB && mem_rdata_i[7:4] >= HI_IMMEDIATE_OPERAND)) begin
                  addr_ff  <= pc_ff + 16'h0001;
                  rd_ff    <= 1'b1;
                  state_ff <= CST_OPND1;
               end else begin
                  state_ff <= CST_PAD;          // Unsupported opcodes idle as a 2-cycle no-op
               end
            end
            CST_OPND1: begin
               pc_ff <= pc_ff + 16'h0001;
               if (op_ff[7:4] == HI_IMMEDIATE_OPERAND) begin
                  acc_ff   <= alu_res;
                  flags_ff[FLG_N] <= alu_n;
                  flags_ff[FLG_Z] <= alu_z;
                  flags_ff[FLG_C] <= alu_c;
                  state_ff <= finish(cnt_ff, op_ff);
                  addr_ff  <= pc_ff + 16'h0001;
                  rd_ff    <= (finish(cnt_ff, op_ff) == CST_FETCH);
               end else if (op_ff[7:4] == HI_EXTENDED_ABSOLUTE || op_ff[7:4] == HI_INDEXED_WORD) begin
                  hold_ff  <= mem_rdata_i;
                  addr_ff  <= pc_ff + 16'h0001;
                  rd_ff    <= 1'b1;
                  state_ff <= CST_OPND2;
               end else begin
                  if (op_ff[7:4] == HI_INDEXED_BYTE || op_ff[7:4] == HI_TST_BYTE) begin
                     addr_ff <= {ZERO_PAGE, idx_ff} + {ZERO_PAGE, mem_rdata_i};
                  end else begin
                     addr_ff <= {ZERO_PAGE, mem_rdata_i};
                  end
                  rd_ff    <= 1'b1;
                  state_ff <= CST_READ;
               end
            end
            CST_OPND2: begin
               pc_ff <= pc_ff + 16'h0001;
               if (op_ff[7:4] == HI_INDEXED_WORD) begin
                  addr_ff <= {hold_ff, mem_rdata_i} + {ZERO_PAGE, idx_ff};
               end else begin
                  addr_ff <= {hold_ff, mem_rdata_i};
               end
               rd_ff    <= 1'b1;
               state_ff <= CST_READ;
            end
            CST_READ: begin
               if (op_ff[7:4] == HI_BIT_BRANCH) begin
                  bit_ff          <= mem_rdata_i[op_ff[3:1]] ^ op_ff[0];
                  flags_ff[FLG_C] <= mem_rdata_i[op_ff[3:1]];
                  addr_ff         <= pc_ff;
                  rd_ff           <= 1'b1;
                  state_ff        <= CST_REL;
               end else begin
                  if (!is_tst) begin
                     acc_ff          <= alu_res;
                     flags_ff[FLG_C] <= alu_c;
                  end
                  flags_ff[FLG_N] <= alu_n;
                  flags_ff[FLG_Z] <= alu_z;
                  addr_ff         <= pc_ff;
                  rd_ff           <= (finish(cnt_ff, op_ff) == CST_FETCH);
                  state_ff        <= finish(cnt_ff, op_ff);
               end
            end
            CST_REL: begin
               // Taken branch lands relative to the address after the offset byte
               pc_ff    <= pc_ff + 16'h0001 + (bit_ff ? {{8{mem_rdata_i[7]}}, mem_rdata_i} : 16'h0000);
               state_ff <= CST_PAD;
            end
            CST_INH: begin
               flags_ff[FLG_N] <= alu_n;
               flags_ff[FLG_Z] <= alu_z;
               addr_ff         <= pc_ff;
               rd_ff           <= (finish(cnt_ff, op_ff) == CST_FETCH);
               state_ff        <= finish(cnt_ff, op_ff);
            end
            CST_PUSH: begin
               sp_ff   <= sp_ff - 8'h01;
               step_ff <= step_ff + 3'h1;
               if (step_ff == STACK_LAST) begin
                  flags_ff[FLG_I] <= 1'b1;
                  addr_ff         <= TRAP_VECTOR;
                  rd_ff           <= 1'b1;
                  state_ff        <= CST_VECH;
               end else begin
                  addr_ff <= {STACK_PAGE, 8'(sp_ff - 8'h01)};
                  wr_ff   <= 1'b1;
                  unique case (step_ff)
                     3'h0:    wdata_ff <= pc_ff[15:8];
                     3'h1:    wdata_ff <= idx_ff;
                     3'h2:    wdata_ff <= acc_ff;
                     default: wdata_ff <= {3'h0, flags_ff};
                  endcase
               end
            end
            CST_VECH: begin
               if (addr_ff == TRAP_VECTOR) begin
                  pc_ff[15:8] <= mem_rdata_i;
                  addr_ff     <= TRAP_VECTOR + 16'h0001;
                  rd_ff       <= 1'b1;
               end else begin
                  pc_ff[7:0]  <= mem_rdata_i;
                  state_ff    <= CST_PAD;
               end
            end
            CST_PULL: begin
               step_ff <= step_ff + 3'h1;
               unique case (step_ff)
                  3'h0:    flags_ff      <= mem_rdata_i[4:0];
                  3'h1:    acc_ff        <= mem_rdata_i;
                  3'h2:    idx_ff        <= mem_rdata_i;
                  3'h3:    pc_ff[15:8]   <= mem_rdata_i;
                  default: pc_ff[7:0]    <= mem_rdata_i;
               endcase
               if (step_ff == STACK_LAST) begin
                  state_ff <= CST_PAD;
               end else begin
                  sp_ff   <= sp_ff + 8'h01;
                  addr_ff <= {STACK_PAGE, 8'(sp_ff + 8'h01)};
                  rd_ff   <= 1'b1;
               end
            end
            CST_PAD: begin
               addr_ff  <= pc_ff;
               rd_ff    <= (finish(cnt_ff, op_ff) == CST_FETCH);
               state_ff <= finish(cnt_ff, op_ff);
            end
         endcase
      end
   end

   assign mem_addr_o            = addr_ff;
   assign mem_rd_o              = rd_ff;
   assign mem_wr_o              = wr_ff;
   assign mem_wdata_o           = wdata_ff;
   assign opcode_fetch_o        = state_ff[0];   // Fetch is the one-hot bit 0, no decode
   assign acc_o                 = acc_ff;
   assign idx_o                 = idx_ff;
   assign sp_o                  = sp_ff;
   assign pc_o                  = pc_ff;
   assign condition_flags_reg_o = flags_ff;
endmodule

// File: cst_pkg.sv
// Constants, opcodes, flag positions and cycle counts for the instruction subset.
// Assumes a byte-wide memory that answers reads within the same clock cycle.
// Summary of operation
// - Subtract takes the memory byte from A, updates N, Z and C, keeps H and I, and runs 2/3/4/5/4/3 cycles.
// - The software trap (83) runs 10 cycles, bumps PC, pushes PC low, PC high, X, A, flags, then sets I and loads the vector.
// - Opcode 97 copies A into X in 2 cycles and leaves every flag alone.
// - Opcode 9F copies X into A in 2 cycles and leaves every flag alone.
// - The test opcodes set N and Z from the operand only, keep C, and run 4/3/3/5/4 cycles.
// - Extended addressing fetches the high then low address byte to form the 16-bit address.
// - Word-offset indexing fetches high then low offset bytes and adds them to X.
// - Byte-offset indexing fetches one offset byte and adds it to X.
// - Bit-test-and-branch reads a direct address byte then a relative offset added to PC when taken.
// - Return from trap increments SP before each pull and restores flags, A, X, PC high, PC low.
package cst_pkg;
   localparam logic [7:0]  OP_SOFTWARE_TRAP      = 8'h83;
   localparam logic [7:0]  OP_RETURN_FROM_TRAP   = 8'h80;
   localparam logic [7:0]  OP_COPY_ACC_TO_INDEX  = 8'h97;
   localparam logic [7:0]  OP_COPY_INDEX_TO_ACC  = 8'h9f;
   localparam logic [7:0]  OP_TEST_ACC           = 8'h4d;
   localparam logic [3:0]  LO_SUB                = 4'h0;
   localparam logic [3:0]  LO_TEST               = 4'hd;
   localparam logic [3:0]  HI_BIT_BRANCH         = 4'h0;
   // Subtract columns
   localparam logic [3:0]  HI_IMMEDIATE_OPERAND  = 4'ha;
   localparam logic [3:0]  HI_DIRECT             = 4'hb;
   localparam logic [3:0]  HI_EXTENDED_ABSOLUTE  = 4'hc;
   localparam logic [3:0]  HI_INDEXED_WORD       = 4'hd;
   localparam logic [3:0]  HI_INDEXED_BYTE       = 4'he;
   localparam logic [3:0]  HI_INDEXED_NONE       = 4'hf;
   // Test columns
   localparam logic [3:0]  HI_TST_DIRECT         = 4'h3;
   localparam logic [3:0]  HI_TST_ACC            = 4'h4;
   localparam logic [3:0]  HI_TST_INDEX          = 4'h5;
   localparam logic [3:0]  HI_TST_BYTE           = 4'h6;
   localparam logic [3:0]  HI_TST_NONE           = 4'h7;
   // Cycle counts
   localparam logic [3:0]  CYC_SUB_IMM           = 4'h2;
   localparam logic [3:0]  CYC_SUB_DIR           = 4'h3;
   localparam logic [3:0]  CYC_SUB_EXT           = 4'h4;
   localparam logic [3:0]  CYC_SUB_IX2           = 4'h5;
   localparam logic [3:0]  CYC_SUB_IX1           = 4'h4;
   localparam logic [3:0]  CYC_SUB_IX            = 4'h3;
   localparam logic [3:0]  CYC_TST_DIR           = 4'h4;
   localparam logic [3:0]  CYC_TST_INH           = 4'h3;
   localparam logic [3:0]  CYC_TST_IX1           = 4'h5;
   localparam logic [3:0]  CYC_TST_IX            = 4'h4;
   localparam logic [3:0]  CYC_TRAP              = 4'ha;
   localparam logic [3:0]  CYC_RETURN            = 4'h9;
   localparam logic [3:0]  CYC_COPY              = 4'h2;
   localparam logic [3:0]  CYC_BIT_BRANCH        = 4'h5;
   localparam logic [3:0]  CYC_OTHER             = 4'h2;
   // Flag positions in condition_flags_reg
   localparam int          FLG_H                 = 4;
   localparam int          FLG_I                 = 3;
   localparam int          FLG_N                 = 2;
   localparam int          FLG_Z                 = 1;
   localparam int          FLG_C                 = 0;
   // Reset values and addresses
   localparam logic [4:0]  FLAGS_RST             = 5'h08;
   localparam logic [7:0]  SP_RST                = 8'hff;
   localparam logic [7:0]  STACK_PAGE            = 8'h00;
   localparam logic [7:0]  ZERO_PAGE             = 8'h00;
   localparam logic [15:0] PC_RST                = 16'h0000;
   localparam logic [15:0] TRAP_VECTOR_ADDR      = 16'hfffc;
   localparam logic [2:0]  STACK_LAST            = 3'h4;
   typedef enum logic [9:0] {
      CST_FETCH = 10'h001,
      CST_OPND1 = 10'h002,
      CST_OPND2 = 10'h004,
      CST_READ  = 10'h008,
      CST_REL   = 10'h010,
      CST_INH   = 10'h020,
      CST_PUSH  = 10'h040,
      CST_PULL  = 10'h080,
      CST_VECH  = 10'h100,
      CST_PAD   = 10'h200
   } cst_state_t;
endpackage

// File: cst_alu.sv
// Subtract and test arithmetic with flag results.
// Assumes the caller decides which flags to write back.
`timescale 1ns/1ps
module cst_alu
   import cst_pkg::*;
(
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic       test_i,
   output logic [7:0]      res_o,
   output logic            neg_o,
   output logic            zero_o,
   output logic            borrow_o
);
   logic [8:0] diff;
   always_comb begin
      diff     = {1'b0, a_i} - {1'b0, b_i};
      res_o    = test_i ? b_i : diff[7:0];
      neg_o    = res_o[7];
      zero_o   = (res_o == 8'h00);
      borrow_o = test_i ? 1'b0 : diff[8];
   end
endmodule

// File: cst_core_asserts.sv
// Port checker for the instruction sequencer.
// Bound to every cst_core; expects memory to answer in the cycle of the read.
`timescale 1ns/1ps
module cst_core_chk
   import cst_pkg::*;
#(
   parameter logic [15:0] TRAP_VECTOR = TRAP_VECTOR_ADDR
)(
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic [15:0] mem_addr_o,
   input  wire logic        mem_rd_o,
   input  wire logic        mem_wr_o,
   input  wire logic [7:0]  mem_wdata_o,
   input  wire logic        opcode_fetch_o,
   input  wire logic [7:0]  acc_o,
   input  wire logic [7:0]  idx_o,
   input  wire logic [7:0]  sp_o,
   input  wire logic [4:0]  condition_flags_reg_o
);
   // Short aliases keep the long sequences readable
   wire        f  = opcode_fetch_o;
   wire [7:0]  d  = mem_rdata_i;
   wire [15:0] ad = mem_addr_o;
   wire [4:0]  fl = condition_flags_reg_o;
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_sub_imm_result: assert property (
      f && d == 8'ha0 |=> !f ##1 f && acc_o == $past(acc_o, 2) - $past(d) && fl[FLG_N] == acc_o[7]
      && fl[FLG_C] == ($past(acc_o, 2) < $past(d)) && fl[4:3] == $past(fl[4:3], 2)) else $error("sub result bad");
   a_ext_addr_order: assert property (
      f && d == 8'hc0 |=> ad == $past(ad) + 16'h1 ##1 ad == $past(ad, 2) + 16'h2
      ##1 mem_rd_o && ad == {$past(d, 2), $past(d)} ##1 f) else $error("extended fetch bad");
   a_word_index_fetch: assert property (
      f && d == 8'hd0 |=> ad == $past(ad) + 16'h1 ##1 ad == $past(ad, 2) + 16'h2 ##1 !f [*2] ##1 f)
      else $error("word offset fetch bad");
   a_byte_index_fetch: assert property (
      f && d == 8'he0 |=> ad == $past(ad) + 16'h1 ##1 !f [*2] ##1 f) else $error("byte offset fetch bad");
   a_trap_stack_seq: assert property (
      f && d == 8'h83 |=> mem_wr_o && ad == {8'h00, $past(sp_o)} && mem_wdata_o == 8'($past(ad) + 16'h1)
      ##1 mem_wr_o && ad == {8'h00, $past(sp_o, 2) - 8'h1} && mem_wdata_o == 8'(($past(ad, 2) + 16'h1) >> 8)
      ##1 mem_wr_o && mem_wdata_o == idx_o ##1 mem_wr_o && mem_wdata_o == acc_o
      ##1 mem_wr_o && mem_wdata_o == {3'b000, fl}
      ##1 fl[FLG_I] && sp_o == $past(sp_o, 6) - 8'h5 && ad == TRAP_VECTOR ##1 ad == TRAP_VECTOR + 16'h1
      ##1 !f [*2] ##1 f && ad == {$past(d, 4), $past(d, 3)}) else $error("trap sequence bad");
   a_copy_to_index: assert property (
      f && d == 8'h97 |=> !f && idx_o == $past(acc_o) ##1 f && fl == $past(fl, 2)) else $error("copy to X bad");
   a_copy_to_acc: assert property (
      f && d == 8'h9f |=> !f && acc_o == $past(idx_o) ##1 f && fl == $past(fl, 2)) else $error("copy to A bad");
   a_test_acc_flags: assert property (
      f && d == 8'h4d |=> !f [*2] ##1 f
      && fl == {$past(fl[4:3], 3), $past(acc_o[7], 3), $past(acc_o, 3) == 8'h00, $past(fl[0], 3)})
      else $error("test flags bad");
   a_branch_target_pc: assert property (
      f && d[7:4] == 4'h0 |=> !f [*4] ##1 f && ad == $past(ad, 5) + 16'h3
      + ((fl[FLG_C] ^ $past(d[0], 5)) ? {{8{$past(d[7], 2)}}, $past(d, 2)} : 16'h0)) else $error("branch bad");
   a_return_pull_order: assert property (
      f && d == 8'h80 |=> ad == {8'h00, $past(sp_o) + 8'h1} ##1 ad == {8'h00, $past(sp_o, 2) + 8'h2}
      ##4 !f [*3] ##1 f && fl == $past(d[4:0], 8) && acc_o == $past(d, 7) && idx_o == $past(d, 6)
      && ad == {$past(d, 5), $past(d, 4)} && sp_o == $past(sp_o, 9) + 8'h5) else $error("return bad");
endmodule

bind cst_core cst_core_chk #(.TRAP_VECTOR(TRAP_VECTOR)) u_chk (
   .core_clk_i            (core_clk_i),
   .nrst_i                (nrst_i),
   .mem_rdata_i           (mem_rdata_i),
   .mem_addr_o            (mem_addr_o),
   .mem_rd_o              (mem_rd_o),
   .mem_wr_o              (mem_wr_o),
   .mem_wdata_o           (mem_wdata_o),
   .opcode_fetch_o        (opcode_fetch_o),
   .acc_o                 (acc_o),
   .idx_o                 (idx_o),
   .sp_o                  (sp_o),
   .condition_flags_reg_o (condition_flags_reg_o)
);

// File: test_cpu_subset_exec_sub_swi_transfer_test.sv
// Self-checking bench running a short program through the sequencer.
// Holds a 64K byte memory that answers reads in the cycle of the read.
`timescale 1ns/1ps
module test_cpu_subset_exec_sub_swi_transfer_test
   import cst_pkg::*;
;
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0]  cyc, acc, idx, sp, flg;
   } cst_row_t;
   // Fields: pc, cycles, A, X, SP, flags seen at the next opcode fetch
   localparam cst_row_t ROWS [21] = '{56'h0000093cc30400, 56'h001002ffc30405, 56'h001202ffff0405,
      56'h00130200ff0402, 56'h001502ffff0402, 56'h001603faff0404, 56'h001804ffff0405, 56'h001b05f0ff0404,
      56'h001e0480ff0404, 56'h00200300ff0402, 56'h002102ffff0405, 56'h002303ffff0405, 56'h002404ffff0403,
      56'h002603ffff0405, 56'h002705ffff0401, 56'h002904ffff0405, 56'h002a05ffff0405, 56'h002f05ffff0404,
      56'h003405ffff0404, 56'h00370affffff0c, 56'h010009ffff0404};
   // Program from 0010; bytes 2d/2e and 32/33 are skipped by taken branches
   localparam logic [319:0] PROG = 320'ha03d97a0ff9fb040c01234d00f01e041f0a0014d3d425d6d417d0040029d9d0340029d9d0240fc83;
   localparam logic [39:0]  STK  = 40'h04ffff0038;
   logic        core_clk_i;
   logic        nrst_i;
   wire  [7:0]  mem_rdata_i;
   logic [15:0] mem_addr_o, pc_o;
   logic        mem_rd_o, mem_wr_o, opcode_fetch_o;
   logic [7:0]  mem_wdata_o, acc_o, idx_o, sp_o;
   logic [4:0]  condition_flags_reg_o;
   logic [7:0]  mem [0:65535];
   int          err_count = 0;
   int          checks_done = 0;
   int          cycles = 0;

   cst_core DUT (
      .core_clk_i            (core_clk_i),
      .nrst_i                (nrst_i),
      .mem_rdata_i           (mem_rdata_i),
      .mem_addr_o            (mem_addr_o),
      .mem_rd_o              (mem_rd_o),
      .mem_wr_o              (mem_wr_o),
      .mem_wdata_o           (mem_wdata_o),
      .opcode_fetch_o        (opcode_fetch_o),
      .acc_o                 (acc_o),
      .idx_o                 (idx_o),
      .sp_o                  (sp_o),
      .pc_o                  (pc_o),
      .condition_flags_reg_o (condition_flags_reg_o)
   );

   assign mem_rdata_i = mem[mem_addr_o];
   always @(posedge core_clk_i) begin
      if (mem_wr_o === 1'b1)
         mem[mem_addr_o] <= mem_wdata_o;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rst();
      cmp(mem_addr_o, PC_RST);
      cmp(pc_o, PC_RST);
      cmp(16'(sp_o), 16'(SP_RST));
      cmp(16'(condition_flags_reg_o), 16'(FLAGS_RST));
      cmp({acc_o, idx_o}, 16'h0000);
      cmp(16'({mem_rd_o, mem_wr_o, opcode_fetch_o}), 16'h0005);
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Ceiling well above the ~90 cycles the program needs
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      int n;
      nrst_i = 1'b0;
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h9d;
      for (int i = 0; i < 40; i++)
         mem[16'h10 + i] = PROG[319 - 8 * i -: 8];
      // Start frame for the first return: flags 00, A 3c, X c3, PC 0010
      {mem[0], mem[1], mem[2], mem[3], mem[4]} = 40'h803cc30010;
      mem[16'h0040] = 8'h05;
      mem[16'h0042] = 8'h00;
      mem[16'h1234] = 8'hfb;
      mem[16'h1000] = 8'h0f;
      mem[16'h0140] = 8'h70;
      mem[16'h00ff] = 8'h80;
      {mem[16'hfffc], mem[16'hfffd]} = 16'h0100;
      mem[16'h0100] = 8'h80;
      repeat (15) @(posedge core_clk_i);
      #1 chk_rst();
      @(posedge core_clk_i);
      nrst_i <= 1'b1;
      #1;
      for (int i = 0; i < 21; i++) begin
         cmp(mem_addr_o, ROWS[i].pc);
         n = 0;
         do begin
            @(posedge core_clk_i);
            #1;
            n++;
         end while (opcode_fetch_o !== 1'b1 && n < 20);
         cmp(16'(n), 16'(ROWS[i].cyc));
         cmp({acc_o, idx_o}, {ROWS[i].acc, ROWS[i].idx});
         cmp(16'(sp_o), 16'(ROWS[i].sp));
         cmp(16'(condition_flags_reg_o), 16'(ROWS[i].flg));
      end
      cmp(mem_addr_o, 16'h0038);
      $display("instruction table test done");
      // Trap frame in page zero: flags, A, X, PC high, PC low
      for (int i = 0; i < 5; i++)
         cmp(16'(mem[i]), 16'(STK[39 - 8 * i -: 8]));
      $display("trap frame test done");
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b0;
      #1 chk_rst();
      $display("mid-run reset test done");
      close_out();
   end
endmodule
